/* src/acl_entry_matcher.sv */
// IPv4 access-control entry matcher with APB configuration
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "acl_entry_params.svh"

module acl_entry_matcher
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_valid,
   input wire acl_entry_pkg::frame_hdr_s frame_hdr,
   output logic result_valid,
   output acl_entry_pkg::match_result_s result
);
   import acl_entry_pkg::*;

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [31:0] ctrl;
   logic [7:0] proto_value;
   logic [31:0] src_addr_cfg;
   logic [31:0] src_mask_cfg;
   logic [31:0] dst_addr_cfg;
   logic [31:0] dst_mask_cfg;
   logic [31:0] hit_count;
   logic last_hit;
   logic last_ipv4_miss;

   logic wr_en;
   logic addr_ok;
   logic [31:0] byte_mask;

   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_comb
   begin
      if (paddr == `REG_CTRL || paddr == `REG_PROTO || paddr == `REG_SRC_ADDR)
         addr_ok = 1'b1;
      else if (paddr == `REG_SRC_MASK || paddr == `REG_DST_ADDR || paddr == `REG_DST_MASK)
         addr_ok = 1'b1;
      else if (paddr == `REG_STATUS || paddr == `REG_HIT_COUNT)
         addr_ok = 1'b1;
      else
         addr_ok = 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_strb
         assign byte_mask[gi*8 +: 8] = {8{pstrb[gi]}};
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
      input logic [31:0] bm);
      merge = (old & ~bm) | (wdata & bm);
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `CTRL_RESET;
         proto_value <= 8'h00;
         src_addr_cfg <= `ADDR_RESET;
         src_mask_cfg <= `MASK_RESET;
         dst_addr_cfg <= `ADDR_RESET;
         dst_mask_cfg <= `MASK_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == `REG_CTRL)
            ctrl <= merge(ctrl, pwdata, byte_mask);
         else if (paddr == `REG_PROTO && pstrb[0])
            proto_value <= pwdata[7:0];
         else if (paddr == `REG_SRC_ADDR)
            src_addr_cfg <= merge(src_addr_cfg, pwdata, byte_mask);
         else if (paddr == `REG_SRC_MASK)
            src_mask_cfg <= merge(src_mask_cfg, pwdata, byte_mask);
         else if (paddr == `REG_DST_ADDR)
            dst_addr_cfg <= merge(dst_addr_cfg, pwdata, byte_mask);
         else if (paddr == `REG_DST_MASK)
            dst_mask_cfg <= merge(dst_mask_cfg, pwdata, byte_mask);
      end
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   frame_type_e frame_type;
   proto_sel_e proto_sel;
   tri_sel_e ttl_sel;
   tri_sel_e frag_sel;
   tri_sel_e opt_sel;
   ip_filter_e src_sel;
   ip_filter_e dst_sel;
   logic entry_en;

   assign frame_type = frame_type_e'(ctrl[`CTRL_FRAME_TYPE_LSB +: 3]);
   assign proto_sel = proto_sel_e'(ctrl[`CTRL_PROTO_SEL_LSB +: 3]);
   assign ttl_sel = tri_sel_e'(ctrl[`CTRL_TTL_SEL_LSB +: 2]);
   assign frag_sel = tri_sel_e'(ctrl[`CTRL_FRAG_SEL_LSB +: 2]);
   assign opt_sel = tri_sel_e'(ctrl[`CTRL_OPT_SEL_LSB +: 2]);
   assign src_sel = ip_filter_e'(ctrl[`CTRL_SRC_SEL_LSB +: 2]);
   assign dst_sel = ip_filter_e'(ctrl[`CTRL_DST_SEL_LSB +: 2]);
   assign entry_en = ctrl[`CTRL_ENABLE_BIT];

   // ----------------------------------------
   // Criteria
   // ----------------------------------------
   logic proto_ok;
   logic ttl_ok;
   logic frag_ok;
   logic opt_ok;
   logic src_ok;
   logic dst_ok;
   logic is_frag;
   logic ipv4_ok;
   logic next_hit;

   assign is_frag = frame_hdr.more_frags || (frame_hdr.frag_offset != 13'h0000);

   always_comb
   begin
      case (proto_sel)
         PR_ANY: proto_ok = 1'b1;
         PR_SPECIFIC: proto_ok = (frame_hdr.protocol == proto_value);
         PR_ICMP: proto_ok = (frame_hdr.protocol == `PROTO_ICMP);
         PR_UDP: proto_ok = (frame_hdr.protocol == `PROTO_UDP);
         PR_TCP: proto_ok = (frame_hdr.protocol == `PROTO_TCP);
         default: proto_ok = 1'b0;
      endcase
   end

   // Unused encodings of the protocol, TTL, fragment, option and address selects never pass, so a bad setting there cannot open the entry wide
   always_comb
   begin
      case (ttl_sel)
         TRI_ANY: ttl_ok = 1'b1;
         TRI_NO: ttl_ok = (frame_hdr.ttl == 8'h00);
         TRI_YES: ttl_ok = (frame_hdr.ttl != 8'h00);
         default: ttl_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (frag_sel)
         TRI_ANY: frag_ok = 1'b1;
         TRI_NO: frag_ok = !is_frag;
         TRI_YES: frag_ok = is_frag;
         default: frag_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (opt_sel)
         TRI_ANY: opt_ok = 1'b1;
         TRI_NO: opt_ok = !frame_hdr.has_options;
         TRI_YES: opt_ok = frame_hdr.has_options;
         default: opt_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (src_sel)
         IPF_ANY: src_ok = 1'b1;
         IPF_HOST: src_ok = (frame_hdr.src_addr == src_addr_cfg);
         IPF_NETWORK: src_ok = ((frame_hdr.src_addr ^ src_addr_cfg) & src_mask_cfg) == '0;
         default: src_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (dst_sel)
         IPF_ANY: dst_ok = 1'b1;
         IPF_HOST: dst_ok = (frame_hdr.dst_addr == dst_addr_cfg);
         IPF_NETWORK: dst_ok = ((frame_hdr.dst_addr ^ dst_addr_cfg) & dst_mask_cfg) == '0;
         default: dst_ok = 1'b0;
      endcase
   end

   // Other frame types leave the IPv4 criteria out of the decision
   always_comb
   begin
      if (frame_type == FT_IPV4)
         ipv4_ok = frame_hdr.is_ipv4 && proto_ok && ttl_ok && frag_ok && opt_ok && src_ok
            && dst_ok;
      else
         ipv4_ok = 1'b1;
   end

   assign next_hit = entry_en && ipv4_ok;

   // ----------------------------------------
   // Result register, one cycle after the frame
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_valid <= 1'b0;
         result <= '0;
      end
      else
      begin
         result_valid <= frame_valid;
         if (frame_valid)
         begin
            result.hit <= next_hit;
            result.icmp_sub_en <= next_hit && frame_type == FT_IPV4 && proto_sel == PR_ICMP;
            result.udp_sub_en <= next_hit && frame_type == FT_IPV4 && proto_sel == PR_UDP;
            result.tcp_sub_en <= next_hit && frame_type == FT_IPV4 && proto_sel == PR_TCP;
         end
      end
   end

   // ----------------------------------------
   // Status and hit counter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hit_count <= 32'h0000_0000;
         last_hit <= 1'b0;
         last_ipv4_miss <= 1'b0;
      end
      else
      begin
         // A hit in the same cycle as a clear still counts
         if (frame_valid && next_hit)
            hit_count <= (wr_en && paddr == `REG_HIT_COUNT) ? 32'h0000_0001 : hit_count + 32'h1;
         else if (wr_en && paddr == `REG_HIT_COUNT)
            hit_count <= 32'h0000_0000;
         if (frame_valid)
         begin
            last_hit <= next_hit;
            last_ipv4_miss <= frame_type == FT_IPV4 && !frame_hdr.is_ipv4;
         end
      end
   end

   // ----------------------------------------
   // Read data, registered in the setup phase
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == `REG_CTRL)
            prdata <= ctrl;
         else if (paddr == `REG_PROTO)
            prdata <= {24'h00_0000, proto_value};
         else if (paddr == `REG_SRC_ADDR)
            prdata <= src_addr_cfg;
         else if (paddr == `REG_SRC_MASK)
            prdata <= src_mask_cfg;
         else if (paddr == `REG_DST_ADDR)
            prdata <= dst_addr_cfg;
         else if (paddr == `REG_DST_MASK)
            prdata <= dst_mask_cfg;
         else if (paddr == `REG_STATUS)
            prdata <= {30'h0000_0000, last_ipv4_miss, last_hit};
         else if (paddr == `REG_HIT_COUNT)
            prdata <= hit_count;
         else
            prdata <= 32'h0000_0000;
      end
   end

endmodule

/* src/acl_entry_params.svh */
// Register offsets, field positions, reset values and protocol numbers of the entry matcher
`ifndef ACL_ENTRY_PARAMS_SVH
`define ACL_ENTRY_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_PROTO 12'h004
`define REG_SRC_ADDR 12'h008
`define REG_SRC_MASK 12'h00C
`define REG_DST_ADDR 12'h010
`define REG_DST_MASK 12'h014
`define REG_STATUS 12'h018
`define REG_HIT_COUNT 12'h01C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_FRAME_TYPE_LSB 0
`define CTRL_PROTO_SEL_LSB 4
`define CTRL_TTL_SEL_LSB 8
`define CTRL_FRAG_SEL_LSB 10
`define CTRL_OPT_SEL_LSB 12
`define CTRL_SRC_SEL_LSB 14
`define CTRL_DST_SEL_LSB 16
`define CTRL_ENABLE_BIT 31
`define CTRL_RESET 32'h0000_0000
`define ADDR_RESET 32'h0000_0000
`define MASK_RESET 32'hFFFF_FFFF

// ----------------------------------------
// Protocol numbers
// ----------------------------------------
`define PROTO_ICMP 8'h01
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11

`endif

/* src/acl_entry_pkg.sv */
// Types shared by the entry matcher
package acl_entry_pkg;

   typedef enum logic [2:0] {FT_ANY = 3'd0, FT_ETH = 3'd1, FT_ARP = 3'd2, FT_IPV4 = 3'd3,
      FT_IPV6 = 3'd4} frame_type_e;
   typedef enum logic [2:0] {PR_ANY = 3'd0, PR_SPECIFIC = 3'd1, PR_ICMP = 3'd2, PR_UDP = 3'd3,
      PR_TCP = 3'd4} proto_sel_e;
   typedef enum logic [1:0] {TRI_ANY = 2'd0, TRI_NO = 2'd1, TRI_YES = 2'd2} tri_sel_e;
   typedef enum logic [1:0] {IPF_ANY = 2'd0, IPF_HOST = 2'd1, IPF_NETWORK = 2'd2} ip_filter_e;

   // Parsed header of one frame from the upstream parser
   typedef struct packed {
      logic is_ipv4;
      logic [7:0] protocol;
      logic [7:0] ttl;
      logic more_frags;
      logic [12:0] frag_offset;
      logic has_options;
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
   } frame_hdr_s;

   // Match report
   typedef struct packed {
      logic hit;
      logic icmp_sub_en;
      logic udp_sub_en;
      logic tcp_sub_en;
   } match_result_s;

endpackage

/* verif/acl_entry_matcher_sva.sv */
// Port-level assertions for the entry matcher
`timescale 1ns/10ps
module acl_entry_matcher_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_valid,
   input wire logic result_valid,
   input wire acl_entry_pkg::match_result_s result
);
   import acl_entry_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ready; pready; endproperty
   property p_answer; frame_valid |=> result_valid; endproperty
   property p_quiet; !frame_valid |=> !result_valid; endproperty
   property p_hold; !result_valid |-> $stable(result); endproperty
   property p_sub_hit; (result.icmp_sub_en || result.udp_sub_en || result.tcp_sub_en) |-> result.hit;
   endproperty
   property p_one_sub; $onehot0({result.icmp_sub_en, result.udp_sub_en, result.tcp_sub_en});
   endproperty
   property p_err_phase; pslverr |-> psel && penable; endproperty
   property p_unmapped; psel && penable && paddr[11:5] != 7'h00 |-> pslverr; endproperty
   property p_mapped; psel && penable && paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   property p_err_data; psel && penable && pslverr && !pwrite |-> prdata == 32'h0000_0000;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_answer: assert property (p_answer) else $error("no result after frame");
   a_quiet: assert property (p_quiet) else $error("result without frame");
   a_hold: assert property (p_hold) else $error("result changed between frames");
   a_sub_hit: assert property (p_sub_hit) else $error("sub-criteria without hit");
   a_one_sub: assert property (p_one_sub) else $error("several sub-criteria set");
   a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   a_err_data: assert property (p_err_data) else $error("refused read data not zero");
   c_hit: cover property (result_valid && result.hit);
   c_tcp: cover property (result_valid && result.tcp_sub_en);
   c_err: cover property (psel && penable && pslverr);
endmodule

bind acl_entry_matcher acl_entry_matcher_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .frame_valid(frame_valid), .result_valid(result_valid), .result(result));

/* verif/frame_src.sv */
// Upstream header parser model: one parsed header per request
`timescale 1ns/10ps
module frame_src
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic send,
   input wire acl_entry_pkg::frame_hdr_s hdr_in,
   output acl_entry_pkg::frame_hdr_s frame_hdr,
   output logic frame_valid
);
   import acl_entry_pkg::*;
   // Header flips once released, so a stale copy can never pass for a new frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_valid <= 1'b0;
         frame_hdr <= '0;
      end
      else
      begin
         frame_valid <= send;
         frame_hdr <= send ? hdr_in : ~frame_hdr;
      end
   end
endmodule

/* verif/ipv4_acl_entry_matcher_tb.sv */
// Self-checking bench for the entry matcher
`timescale 1ns/10ps
`include "acl_entry_params.svh"
module ipv4_acl_entry_matcher_tb;
   import acl_entry_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, frame_valid, result_valid, send, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   frame_hdr_s frame_hdr, hdr_in, c, h;
   match_result_s result;
   int error_cnt = 0;
   int checks_done = 0;
   proto_sel_e sels[3] = '{PR_ICMP, PR_UDP, PR_TCP};
   logic [7:0] nums[3] = '{8'h01, 8'h11, 8'h06};
   logic [3:0] exps[3] = '{4'hC, 4'hA, 4'h9};

   acl_entry_matcher uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_hdr(frame_hdr),
      .result_valid(result_valid), .result(result));
   frame_src src (.pclk(pclk), .presetn(presetn), .send(send), .hdr_in(hdr_in),
      .frame_hdr(frame_hdr), .frame_valid(frame_valid));

   always #10 pclk = ~pclk;

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the slave
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp, input logic expe);
      apb(1'b0, a, 32'h0000_0000);
      cmp("prdata", exp, q);
      cmp("pslverr", {31'h0, expe}, {31'h0, e});
   endtask

   task cfg(input logic [2:0] pr, input logic [1:0] tl, fr, op, sr, ds);
      logic [31:0] v;
      v = (32'h1 << `CTRL_ENABLE_BIT) | 32'(FT_IPV4) | (32'(pr) << `CTRL_PROTO_SEL_LSB);
      v = v | (32'(tl) << `CTRL_TTL_SEL_LSB) | (32'(fr) << `CTRL_FRAG_SEL_LSB);
      v = v | (32'(op) << `CTRL_OPT_SEL_LSB) | (32'(sr) << `CTRL_SRC_SEL_LSB);
      wr(`REG_CTRL, v | (32'(ds) << `CTRL_DST_SEL_LSB));
   endtask

   task run(input frame_hdr_s f, input logic [3:0] exp);
      int n;
      @(posedge pclk);
      send <= 1'b1;
      hdr_in <= f;
      @(posedge pclk);
      send <= 1'b0;
      n = 0;
      @(negedge pclk);
      while (result_valid !== 1'b1 && n < 8)
      begin
         n++;
         @(negedge pclk);
      end
      cmp("result_valid", 32'h1, {31'h0, result_valid});
      cmp("result", {28'h0, exp}, {28'h0, result});
   endtask

   task results;
      $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      #100_000;
      error_cnt++;
      results;
   end

   initial
   begin
      {presetn, psel, penable, pwrite, send} = 5'h00;
      {paddr, pwdata, hdr_in} = '0;
      pstrb = 4'hF;
      c = '0;
      c.is_ipv4 = 1'b1;
      c.protocol = 8'h06;
      c.src_addr = 32'hC0A8_0001;
      c.dst_addr = 32'h0A00_0005;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`REG_CTRL, 32'h0000_0000, 1'b0);
      rd(`REG_SRC_MASK, 32'hFFFF_FFFF, 1'b0);
      rd(12'h020, 32'h0000_0000, 1'b1);
      run(c, 4'h0);
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_ANY, IPF_ANY, IPF_ANY);
      h = '1;
      run(h, 4'h8);
      wr(`REG_PROTO, 32'h0000_00FF);
      cfg(PR_SPECIFIC, TRI_ANY, TRI_ANY, TRI_ANY, IPF_ANY, IPF_ANY);
      run(h, 4'h8);
      run(c, 4'h0);
      for (int i = 0; i < 3; i++)
      begin
         cfg(sels[i], TRI_ANY, TRI_ANY, TRI_ANY, IPF_ANY, IPF_ANY);
         h = c;
         h.protocol = nums[i];
         run(h, exps[i]);
         h.protocol = nums[(i + 1) % 3];
         run(h, 4'h0);
      end
      h = c;
      h.ttl = 8'h01;
      cfg(PR_ANY, TRI_NO, TRI_ANY, TRI_ANY, IPF_ANY, IPF_ANY);
      run(c, 4'h8);
      run(h, 4'h0);
      cfg(PR_ANY, TRI_YES, TRI_ANY, TRI_ANY, IPF_ANY, IPF_ANY);
      run(h, 4'h8);
      run(c, 4'h0);
      h = c;
      h.more_frags = 1'b1;
      cfg(PR_ANY, TRI_ANY, TRI_NO, TRI_ANY, IPF_ANY, IPF_ANY);
      run(h, 4'h0);
      run(c, 4'h8);
      h = c;
      h.frag_offset = 13'h0001;
      run(h, 4'h0);
      cfg(PR_ANY, TRI_ANY, TRI_YES, TRI_ANY, IPF_ANY, IPF_ANY);
      run(h, 4'h8);
      run(c, 4'h0);
      h = c;
      h.has_options = 1'b1;
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_NO, IPF_ANY, IPF_ANY);
      run(h, 4'h0);
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_YES, IPF_ANY, IPF_ANY);
      run(h, 4'h8);
      run(c, 4'h0);
      wr(`REG_SRC_ADDR, 32'hC0A8_0001);
      wr(`REG_SRC_MASK, 32'hFFFF_FF00);
      wr(`REG_DST_ADDR, 32'h0A00_0005);
      wr(`REG_DST_MASK, 32'hFFFF_FF00);
      h = c;
      h.src_addr = 32'hC0A8_0003;
      h.dst_addr = 32'h0A00_0007;
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_ANY, IPF_HOST, IPF_ANY);
      run(c, 4'h8);
      run(h, 4'h0);
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_ANY, IPF_ANY, IPF_HOST);
      run(c, 4'h8);
      run(h, 4'h0);
      cfg(PR_ANY, TRI_ANY, TRI_ANY, TRI_ANY, IPF_NETWORK, IPF_NETWORK);
      run(h, 4'h8);
      h.src_addr = 32'hC1A8_0001;
      run(h, 4'h0);
      h = c;
      h.dst_addr = 32'h0A01_0005;
      run(h, 4'h0);
      cfg(PR_TCP, TRI_NO, TRI_NO, TRI_NO, IPF_HOST, IPF_HOST);
      run(c, 4'h9);
      run(h, 4'h0);
      h = c;
      h.is_ipv4 = 1'b0;
      run(h, 4'h0);
      h.ttl = 8'h01;
      wr(`REG_CTRL, 32'h8000_0001);
      run(h, 4'h8);
      rd(`REG_HIT_COUNT, 32'h0000_000F, 1'b0);
      rd(`REG_STATUS, 32'h0000_0001, 1'b0);
      wr(`REG_HIT_COUNT, 32'h0000_0000);
      rd(`REG_HIT_COUNT, 32'h0000_0000, 1'b0);
      results;
   end
endmodule
